// File: logic/nav_sched_cfg.svh
`ifndef NAV_SCHED_CFG_SVH
`define NAV_SCHED_CFG_SVH
// Register byte offsets
`define OFS_FIX_IV 12'h000
`define OFS_MIN_IV 12'h004
`define OFS_GSV_IV 12'h008
`define OFS_ZDA_IV 12'h00c
`define OFS_POS_IV 12'h010
`define OFS_VEL_IV 12'h014
`define OFS_ACC_IV 12'h018
`define OFS_STATUS 12'h01c
`define OFS_CAL_BASE 12'h020
`define OFS_CAL_COMMIT 12'h038
`define OFS_BAUD 12'h03c
// Status fields
`define ST_FIX_BIT 0
`define ST_PEND_LSB 8
`define ST_LOCK_LSB 16
// Reset values
`define CAL_OFFSET_RST 32'h0000_0000
`define CAL_GAIN_RST 32'h3f80_0000
`define IV_RST 8'h00
// Timing
`define CLK_HZ 20000000
`define ACC_STEP_MS 50
`define BAUD_DEFAULT 115200
`define BAUD_DIV_RST ((`CLK_HZ + `BAUD_DEFAULT / 2) / `BAUD_DEFAULT)
`define TICKS_50MS ((`CLK_HZ / 1000) * `ACC_STEP_MS)
// Report contents
`define POS_LEN 115
`define ACC_VALUES 6
`define VEL_FIELDS 6
`define POS_FIELDS 17
`define MAX_GSV 6
`endif

// File: logic/nav_sched_pkg.sv
package nav_sched_pkg;
  typedef enum logic [6:0] {
    KIND_FIX = 7'h01,
    KIND_MIN = 7'h02,
    KIND_GSV = 7'h04,
    KIND_ZDA = 7'h08,
    KIND_POS = 7'h10,
    KIND_VEL = 7'h20,
    KIND_ACC = 7'h40
  } report_kind_t;

  typedef struct packed {
    logic [6:0] kind;
    logic [7:0] lock_state;
    logic height_msl;
    logic [2:0] gsv_total;
    logic [6:0] length;
    logic [4:0] fields;
  } report_t;

  typedef struct packed {
    logic [2:0] sys;
    logic [7:0] id;
  } sat_ref_t;
endpackage

// File: logic/nav_sentence_scheduler.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "nav_sched_cfg.svh"
module nav_sentence_scheduler #(
  parameter int TICKS_50MS = `TICKS_50MS,
  parameter int MAX_GSV = `MAX_GSV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver status
  input wire logic sec_tick,
  input wire logic first_fix,
  input wire logic [7:0] lock_state,
  input wire logic [2:0] gsv_count,
  input wire nav_sched_pkg::sat_ref_t sat_ref,
  // Report requests to the sentence formatter
  output logic rpt_valid,
  output nav_sched_pkg::report_t rpt,
  input wire logic rpt_ready,
  // Derived outputs
  output logic [8:0] satellite_number,
  output logic [15:0] baud_div,
  output logic [191:0] cal_active
);

  if (TICKS_50MS < 2) begin : g_chk_tick
    $error("TICKS_50MS must be at least 2");
  end
  if (MAX_GSV < 1 || MAX_GSV > 7) begin : g_chk_gsv
    $error("MAX_GSV must be 1..7");
  end

  localparam int NK = 7;
  localparam int ACC = 6;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [6:0] lowest_one(input logic [6:0] v);
    lowest_one = v & (~v + 7'h01);
  endfunction

  // Unknown GLONASS slot stays zero rather than wrapping to 64
  function automatic logic [8:0] sat_num(input nav_sched_pkg::sat_ref_t s);
    logic [8:0] id;
    id = {1'b0, s.id};
    unique case (s.sys)
      3'h0: sat_num = id;
      3'h1: sat_num = (id >= 9'h098) ? id : id - 9'h057;
      3'h2: sat_num = id + 9'h12c;
      3'h3: sat_num = id + 9'h190;
      3'h4: sat_num = id + 9'h0ac;
      3'h5: sat_num = id + 9'h0c0;
      3'h6: sat_num = (id == 9'h000) ? 9'h000 : id + 9'h040;
      default: sat_num = 9'h000;
    endcase
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [7:0] iv_reg [NK];
  logic [31:0] cal_shadow_reg [6];
  logic [31:0] cal_reg [6];
  logic [15:0] baud_reg;
  logic [6:0] pend_reg;
  logic [31:0] prdata_next;
  logic err_next;

  wire setup = psel && !penable;
  wire wr_setup = setup && pwrite;
  wire [9:0] widx = paddr[11:2];
  wire is_iv = (widx < 10'd7);
  wire is_cal = (widx >= 10'd8) && (widx < 10'd14);
  wire [2:0] cal_idx = 3'(widx - 10'd8);
  wire is_status = (paddr == `OFS_STATUS);
  wire is_commit = (paddr == `OFS_CAL_COMMIT);
  wire is_baud = (paddr == `OFS_BAUD);
  wire mapped = (paddr[1:0] == 2'b00) &&
                (is_iv || is_cal || is_status || is_commit || is_baud);
  // six factors staged, applied together on commit
  wire cal_apply = wr_setup && mapped && is_commit;

  always_comb begin
    prdata_next = 32'h0000_0000;
    if (is_iv) begin
      prdata_next = {24'h000000, iv_reg[3'(widx)]};
    end else if (is_cal) begin
      prdata_next = cal_reg[cal_idx];
    end else if (is_status) begin
      prdata_next[`ST_FIX_BIT] = first_fix;
      prdata_next[`ST_PEND_LSB +: 7] = pend_reg;
      prdata_next[`ST_LOCK_LSB +: 8] = lock_state;
    end else if (is_baud) begin
      prdata_next = {16'h0000, baud_reg};
    end
    if (!mapped) begin
      prdata_next = 32'h0000_0000;
    end
  end
  // Misaligned or unmapped: error flag, zero data, write dropped
  assign err_next = setup && !mapped;

  // Zero-wait answer: ready in the access cycle after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= err_next;
      if (setup && !pwrite) begin
        prdata <= prdata_next;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Writes commit in the setup cycle; the access cycle always completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NK; i++) begin
        iv_reg[i] <= `IV_RST;
      end
      for (int i = 0; i < 6; i++) begin
        cal_shadow_reg[i] <= (i < 3) ? `CAL_OFFSET_RST : `CAL_GAIN_RST;
        cal_reg[i] <= (i < 3) ? `CAL_OFFSET_RST : `CAL_GAIN_RST;
      end
      baud_reg <= 16'(`BAUD_DIV_RST);
    end else if (wr_setup && mapped) begin
      if (is_iv) begin
        iv_reg[3'(widx)] <= pwdata[7:0];
      end
      if (is_cal) begin
        cal_shadow_reg[cal_idx] <= pwdata;
      end
      if (is_baud) begin
        baud_reg <= pwdata[15:0];
      end
      if (is_commit) begin
        for (int i = 0; i < 6; i++) begin
          cal_reg[i] <= cal_shadow_reg[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  // Counts in clocks, so TICKS_50MS must track the real pclk
  logic [$clog2(TICKS_50MS)-1:0] step_cnt_reg;
  logic step_tick;
  wire step_wrap = (step_cnt_reg == ($clog2(TICKS_50MS))'(TICKS_50MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= '0;
      step_tick <= 1'b0;
    end else begin
      step_cnt_reg <= step_wrap ? '0 : step_cnt_reg + 1'b1;
      step_tick <= step_wrap;
    end
  end

  // ----------------------------------------
  // Per-report interval counters
  // ----------------------------------------
  logic [7:0] cnt_reg [NK];
  logic [6:0] fire;
  logic [6:0] grant;
  logic [6:0] pend_next;
  // Counters run while gated, so reports keep their phase after fix
  wire [6:0] gated = {2'b11, {5{first_fix}}};

  for (genvar k = 0; k < NK; k++) begin : g_iv
    // seconds from the common tick; accel from 50 ms steps
    // A new nonzero interval takes hold only at the next reload; zero disables at once
    wire tick = (k == ACC) ? step_tick : sec_tick;
    wire en = (iv_reg[k] != 8'h00);
    wire due = (cnt_reg[k] <= 8'h01);
    assign fire[k] = tick && en && due && gated[k];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg[k] <= 8'h00;
      end else if (!en) begin
        cnt_reg[k] <= 8'h00;
      end else if (tick) begin
        cnt_reg[k] <= due ? iv_reg[k] : cnt_reg[k] - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Arbitration and report output
  // ----------------------------------------
  // Fixed priority: a busy velocity stream can delay accel by cycles
  wire slot_free = !rpt_valid || rpt_ready;
  assign grant = slot_free ? lowest_one(pend_reg) : 7'h00;
  // New firing wins over the grant of the same kind
  assign pend_next = fire | (pend_reg & ~grant);

  wire [2:0] gsv_lim = 3'(MAX_GSV);
  // up to six sentences in one second
  wire [2:0] gsv_tot = (gsv_count == 3'h0) ? 3'h1 :
                       (gsv_count > gsv_lim) ? gsv_lim : gsv_count;

  nav_sched_pkg::report_t rpt_next;
  always_comb begin
    rpt_next = '0;
    rpt_next.kind = grant;
    // lock state replaces the validity flag
    rpt_next.lock_state = grant[0] ? lock_state : 8'h00;
    rpt_next.height_msl = grant[0] | grant[4];
    rpt_next.gsv_total = grant[2] ? gsv_tot : 3'h0;
    rpt_next.length = grant[4] ? 7'(`POS_LEN) : 7'h00;
    if (grant[4]) begin
      rpt_next.fields = 5'(`POS_FIELDS);
    end else if (grant[5]) begin
      rpt_next.fields = 5'(`VEL_FIELDS);
    end else if (grant[6]) begin
      rpt_next.fields = 5'(`ACC_VALUES);
    end
  end

  // nothing here stalls the command path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 7'h00;
      rpt_valid <= 1'b0;
      rpt <= '0;
      satellite_number <= 9'h000;
    end else begin
      pend_reg <= pend_next;
      if (grant != 7'h00) begin
        rpt_valid <= 1'b1;
        rpt <= rpt_next;
      end else if (rpt_ready) begin
        rpt_valid <= 1'b0;
      end
      satellite_number <= sat_num(sat_ref);
    end
  end

  assign baud_div = baud_reg;
  for (genvar i = 0; i < 6; i++) begin : g_cal
    assign cal_active[i*32 +: 32] = cal_reg[i];
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fix_gate_a: assert property (
    !first_fix |=> (pend_reg[4:0] & ~$past(pend_reg[4:0])) == 5'h00)
    else $error("nav report fired before first fix");
  zero_off_a: assert property (
    (iv_reg[ACC] == 8'h00) |-> !fire[ACC])
    else $error("accel fired with zero period");
  one_sec_a: assert property (
    (sec_tick && first_fix && iv_reg[0] == 8'h01) |-> fire[0])
    else $error("fix report missed interval 1");
  vel_gap_a: assert property (
    fire[5] && iv_reg[5] == 8'h02 ##1 (iv_reg[5] == 8'h02)[*1] |->
    cnt_reg[5] == 8'h02)
    else $error("velocity counter not reloaded");
  pend_hold_a: assert property (
    fire[1] |=> pend_reg[1])
    else $error("firing lost");
  pos_len_a: assert property (
    (rpt_valid && rpt.kind == 7'h10) |-> rpt.length == 7'd115)
    else $error("position sentence length wrong");
  lock_copy_a: assert property (
    grant[0] |=> rpt.lock_state == $past(lock_state))
    else $error("lock state not carried");
  gsv_max_a: assert property (
    rpt_valid |-> rpt.gsv_total <= 3'(MAX_GSV))
    else $error("too many view sentences");
  cal_atomic_a: assert property (
    !$past(cal_apply) |-> $stable(cal_reg[0]) && $stable(cal_reg[5]))
    else $error("calibration changed without commit");
  acc_readback_a: assert property (
    (setup && !pwrite && paddr == `OFS_ACC_IV) |=>
    prdata == {24'h000000, iv_reg[ACC]})
    else $error("accel period readback wrong");
  glo_zero_a: assert property (
    (sat_ref.sys == 3'h6 && sat_ref.id == 8'h00) |=>
    satellite_number == 9'h000)
    else $error("unknown glonass not zero");
  ans_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not a single access cycle");

  // ----------------------------------------
  // Descriptor, gating, counter, handshake and readback assertions
  // ----------------------------------------
  // The formatter trusts these fields, so the fix, view, position, velocity and accel kinds are pinned here
  msl_flag_a: assert property (
    (rpt_valid && rpt.kind == 7'h01) |-> rpt.height_msl)
    else $error("fix report height not msl");
  gsv_floor_a: assert property (
    (rpt_valid && rpt.kind == 7'h04) |-> rpt.gsv_total != 3'h0)
    else $error("view report with no sentences");
  vel_fields_a: assert property (
    (rpt_valid && rpt.kind == 7'h20) |-> rpt.fields == 5'd6)
    else $error("velocity field count wrong");
  pos_fields_a: assert property (
    (rpt_valid && rpt.kind == 7'h10) |-> rpt.fields == 5'd17)
    else $error("position field count wrong");
  acc_fields_a: assert property (
    (rpt_valid && rpt.kind == 7'h40) |-> rpt.fields == 5'd6)
    else $error("accel value count wrong");
  // Velocity is not held back by the fix gate
  vel_free_a: assert property (
    (sec_tick && !first_fix && iv_reg[5] != 8'h00 &&
     cnt_reg[5] <= 8'h01) |-> fire[5])
    else $error("velocity report held without fix");
  zero_clear_a: assert property (
    (iv_reg[1] == 8'h00) |=> cnt_reg[1] == 8'h00)
    else $error("disabled counter not cleared");
  rpt_hold_a: assert property (
    (rpt_valid && !rpt_ready) |=> rpt_valid && $stable(rpt))
    else $error("report changed while stalled");
  baud_readback_a: assert property (
    (setup && !pwrite && paddr == `OFS_BAUD) |=>
    prdata == {16'h0000, $past(baud_reg)})
    else $error("baud readback wrong");
  cal_readback_a: assert property (
    (setup && !pwrite && is_cal && mapped) |=>
    prdata == $past(cal_reg[cal_idx]))
    else $error("calibration readback wrong");

  fix_cov_c: cover property (grant[0] ##1 rpt_valid);
  acc_cov_c: cover property (fire[ACC]);
  multi_cov_c: cover property ($countones(pend_reg) > 1);
  cal_cov_c: cover property (cal_apply);
  stall_cov_c: cover property (rpt_valid && !rpt_ready);

endmodule

// File: test/rpt_sink.sv
`timescale 1ns/1ps
// ----
// Formatter stand-in, may stall
// ----
module rpt_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Report handshake
  input wire logic rpt_valid,
  input wire nav_sched_pkg::report_t rpt,
  output logic rpt_ready,
  // Bench side
  input wire logic stall,
  output logic [15:0] taken,
  output nav_sched_pkg::report_t last
);
  assign rpt_ready = ~stall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken <= 16'h0000;
      last <= '0;
    end else if (rpt_valid && rpt_ready) begin
      taken <= taken + 16'h0001;
      last <= rpt;
    end
  end
endmodule

// File: test/nav_sentence_scheduler_tb_top.sv
`timescale 1ns/1ps
`include "nav_sched_cfg.svh"
module nav_sentence_scheduler_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sec_tick = 1'b0;
  logic first_fix = 1'b0;
  logic [7:0] lock_state = 8'h00;
  logic [2:0] gsv_count = 3'h0;
  nav_sched_pkg::sat_ref_t sat_ref = '0;
  logic stall = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rpt_valid, rpt_ready, err;
  nav_sched_pkg::report_t rpt, last;
  logic [8:0] satellite_number;
  logic [15:0] baud_div, taken, c0;
  logic [191:0] cal_active;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 pclk = ~pclk;

  nav_sentence_scheduler #(.TICKS_50MS(20)) nav_sentence_scheduler_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sec_tick(sec_tick),
    .first_fix(first_fix), .lock_state(lock_state),
    .gsv_count(gsv_count), .sat_ref(sat_ref), .rpt_valid(rpt_valid),
    .rpt(rpt), .rpt_ready(rpt_ready),
    .satellite_number(satellite_number), .baud_div(baud_div),
    .cal_active(cal_active));

  rpt_sink rpt_sink_inst (.pclk(pclk), .presetn(presetn),
    .rpt_valid(rpt_valid), .rpt(rpt), .rpt_ready(rpt_ready),
    .stall(stall), .taken(taken), .last(last));

  // ----
  // Bus and check helpers
  // ----
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      sec_tick <= 1'b1;
      @(posedge pclk);
      sec_tick <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----
  // Scenarios
  // ----
  task automatic regs_test();
    check("baud_div", baud_div, 32'h0000_00ae);
    rd_chk("baud", `OFS_BAUD, 32'h0000_00ae);
    for (int i = 0; i < 6; i++) begin
      rd_chk("cal", 12'(32 + 4 * i), i < 3 ? 0 : 32'h3f80_0000);
      apb(1'b1, 12'(32 + 4 * i), 32'h4000_0000 + i);
    end
    rd_chk("uncommitted", `OFS_CAL_BASE, 32'h0000_0000);
    apb(1'b1, `OFS_CAL_COMMIT, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      rd_chk("cal", 12'(32 + 4 * i), 32'h4000_0000 + i);
      check("cal_active", cal_active[i*32+:32], 32'h4000_0000 + i);
    end
    for (int i = 0; i < 7; i++) begin
      rd_chk("interval", 12'(4 * i), 32'h0000_0000);
      apb(1'b1, 12'(4 * i), 32'h0000_00ff - i);
      rd_chk("interval", 12'(4 * i), 32'h0000_00ff - i);
      apb(1'b1, 12'(4 * i), 32'h0000_0000);
    end
    rd_chk("unmapped", 12'h040, 32'h0000_0000);
    check("slverr", err, 32'h0000_0001);
  endtask

  task automatic accel_test();
    for (int n = 3; n >= 0; n--) begin
      apb(1'b1, `OFS_ACC_IV, n);
      repeat (100) @(posedge pclk);
      c0 = taken;
      repeat (240) @(posedge pclk);
      check("accel", taken - c0, n ? 12 / n : 0);
    end
  endtask

  task automatic gate_test();
    for (int i = 0; i < 5; i++) apb(1'b1, 12'(4 * i), 32'h0000_0001);
    c0 = taken;
    ticks(3);
    check("gated", taken - c0, 32'h0000_0000);
    first_fix <= 1'b1;
    stall <= 1'b1;
    ticks(1);
    check("held kind", rpt.kind, nav_sched_pkg::KIND_FIX);
    rd_chk("status", `OFS_STATUS, 32'h0000_1e01);
    stall <= 1'b0;
    repeat (20) @(posedge pclk);
    check("released", taken - c0, 32'h0000_0005);
    check("pos len", last.length, 32'h0000_0073);
    check("pos fields", last.fields, 32'h0000_0011);
    for (int i = 0; i < 5; i++) apb(1'b1, 12'(4 * i), 32'h0000_0000);
    repeat (20) @(posedge pclk);
  endtask

  task automatic fix_vel_test();
    lock_state <= 8'h2a;
    apb(1'b1, `OFS_FIX_IV, 32'h0000_0002);
    c0 = taken;
    ticks(5);
    check("fix count", taken - c0, 32'h0000_0003);
    check("lock", last.lock_state, 32'h0000_002a);
    check("msl", last.height_msl, 32'h0000_0001);
    apb(1'b1, `OFS_FIX_IV, 32'h0000_0000);
    first_fix <= 1'b0;
    apb(1'b1, `OFS_VEL_IV, 32'h0000_0003);
    c0 = taken;
    ticks(7);
    check("vel count", taken - c0, 32'h0000_0003);
    check("vel kind", last.kind, nav_sched_pkg::KIND_VEL);
    check("vel fields", last.fields, 32'h0000_0006);
    apb(1'b1, `OFS_VEL_IV, 32'h0000_0000);
    first_fix <= 1'b1;
    gsv_count <= 3'h7;
    apb(1'b1, `OFS_GSV_IV, 32'h0000_0001);
    ticks(1);
    check("gsv total", last.gsv_total, 32'h0000_0006);
    apb(1'b1, `OFS_GSV_IV, 32'h0000_0000);
  endtask

  task automatic sat_test();
    int sys[10] = '{0, 1, 1, 1, 2, 3, 4, 5, 6, 6};
    int id[10] = '{32, 120, 151, 152, 36, 1, 10, 5, 0, 32};
    int ex[10] = '{32, 33, 64, 152, 336, 401, 182, 197, 0, 96};
    for (int i = 0; i < 10; i++) begin
      sat_ref <= '{sys: 3'(sys[i]), id: 8'(id[i])};
      repeat (3) @(posedge pclk);
      check("sat number", satellite_number, ex[i]);
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs_test();
    accel_test();
    gate_test();
    fix_vel_test();
    sat_test();
    wrap_up();
  end
endmodule
